// *** core/psm_port.sv ***
// parallel slave port: strap-selected 8/16-bit bus front end
// assumes host pins are asynchronous; internal memory on the user side
// How it works
// - direction high reads, low writes, during enable
// - enable mode floats unless select, enable, direction high
// - enable drives read data, undefined until access time
// - strobe mode drives sixteen lines while select, read
// - 16-bit reads always return whole word
// - low/high write strobes store their byte lane
// - byte-select: direction picks, lane select performs
// - byte-select floats unless select, direction, lane high
// - lane selects store lower or upper byte
// - latch mode: lines 8-14 are address-only inputs
// - latch strobe captures full address
// - latch mode drives low byte only on read
// - repeated strobes reuse the latched address
// - latched address held until reset or relatch
`include "psm_map.svh"
module psm_port #(
  parameter int AW = `PSM_ADDR_W,
  parameter int DW = `PSM_DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_mode_strap_0,
  input wire logic bus_mode_strap_1,
  input wire logic bus_mode_strap_2,
  input wire logic bus_mode_strap_3,
  input wire logic bus_mode_strap_4,
  input wire logic small_package,
  input wire logic chip_select,
  input wire logic rd_strobe,
  input wire logic rw_select,
  input wire logic low_byte_write_strobe,
  input wire logic high_byte_write_strobe,
  input wire logic address_latch_strobe,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] ad_in,
  output logic [DW-1:0] ad_out,
  output logic [DW-1:0] ad_oe,
  output logic [AW-1:0] mem_addr,
  output logic mem_rd,
  input wire logic [DW-1:0] mem_rdata,
  output logic mem_wr,
  output logic [1:0] mem_wr_be,
  output logic [DW-1:0] mem_wdata,
  output logic [4:0] active_mode
);
  localparam int ACC = `PSM_ACCESS_CYC;
  // ****************************************************
  // synchronisers
  // ****************************************************
  logic [5:0] ctl_s;
  logic [DW-1:0] ad_s;
  logic [AW-1:0] a_s;
  psm_sync #(.W(6)) u_sync_ctl (
    .clk(clk),
    .rst(rst),
    .d({chip_select, rd_strobe, rw_select, low_byte_write_strobe,
        high_byte_write_strobe, address_latch_strobe}),
    .q(ctl_s)
  );
  psm_sync #(.W(DW)) u_sync_ad (.clk(clk), .rst(rst), .d(ad_in), .q(ad_s));
  psm_sync #(.W(AW)) u_sync_a (.clk(clk), .rst(rst), .d(addr_in), .q(a_s));
  logic cs_s, rd_s, rw_s, wl_s, wh_s, al_s;
  assign {cs_s, rd_s, rw_s, wl_s, wh_s, al_s} = ctl_s;
  // ****************************************************
  // mode straps, caught after reset release
  // ****************************************************
  psm_pkg::psm_mode_e mode_ff, nxt_mode;
  logic [4:0] strap_s;
  psm_sync #(.W(5)) u_sync_strap (
    .clk(clk),
    .rst(rst),
    .d({bus_mode_strap_4, bus_mode_strap_3, bus_mode_strap_2,
        bus_mode_strap_1, bus_mode_strap_0}),
    .q(strap_s)
  );
  logic small_s;
  psm_sync #(.W(1)) u_sync_pkg (.clk(clk), .rst(rst), .d(small_package), .q(small_s));
  always_comb begin
    nxt_mode = mode_ff;
    if (mode_ff == psm_pkg::PSM_IDLE) begin
      if (small_s) begin
        // other small-package modes are outside this block
        if (!strap_s[0]) nxt_mode = psm_pkg::PSM_LAT8;
      end else if (!strap_s[2] && !strap_s[3] && strap_s[4]) begin
        nxt_mode = psm_pkg::PSM_E8;
      end else if (strap_s[2] && !strap_s[3] && !strap_s[4]) begin
        nxt_mode = psm_pkg::PSM_W16;
      end else if (strap_s[2] && !strap_s[3] && strap_s[4]) begin
        nxt_mode = psm_pkg::PSM_B16;
      end else if (!strap_s[1] && !strap_s[2] && strap_s[3]) begin
        nxt_mode = psm_pkg::PSM_LAT8;
      end
    end
  end
  // ****************************************************
  // strobe decode per mode
  // ****************************************************
  logic rd_act, wr_act;
  logic [1:0] wr_lanes;
  always_comb begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    wr_lanes = 2'b00;
    case (mode_ff)
      psm_pkg::PSM_E8: begin
        // the enable strobe reuses the read pin, direction on rw_select
        rd_act = cs_s && rd_s && rw_s;
        wr_act = cs_s && rd_s && !rw_s;
        wr_lanes = 2'b01;
      end
      psm_pkg::PSM_W16: begin
        rd_act = cs_s && rd_s;
        wr_act = cs_s && (wl_s || wh_s);
        wr_lanes = {wh_s, wl_s};
      end
      psm_pkg::PSM_B16: begin
        // lane selects arrive on the write strobe pins
        rd_act = cs_s && rw_s && (wl_s || wh_s);
        wr_act = cs_s && !rw_s && (wl_s || wh_s);
        wr_lanes = {wh_s, wl_s};
      end
      psm_pkg::PSM_LAT8: begin
        rd_act = cs_s && rd_s;
        wr_act = cs_s && wl_s;
        wr_lanes = 2'b01;
      end
      default: begin
        rd_act = 1'b0;
      end
    endcase
  end
  // ****************************************************
  // address latch, read timing, write commit
  // ****************************************************
  logic [AW-1:0] lat_ff, nxt_lat;
  logic al_prev_ff, nxt_al_prev;
  logic wr_prev_ff, nxt_wr_prev;
  logic [1:0] lanes_ff, nxt_lanes;
  logic [DW-1:0] wdat_ff, nxt_wdat;
  logic [3:0] acc_ff, nxt_acc;
  logic [DW-1:0] rdat_ff, nxt_rdat;
  logic [DW-1:0] oe_ff, nxt_oe;
  logic mwr_ff, nxt_mwr;
  logic lat_mode;
  assign lat_mode = (mode_ff == psm_pkg::PSM_LAT8);
  always_comb begin
    nxt_lat = lat_ff;
    nxt_al_prev = cs_s && al_s;
    // capture on falling edge of the latch strobe; held otherwise
    if (lat_mode && al_prev_ff && !al_s) begin
      nxt_lat = {ad_s[AW-1:8], ad_s[7:0]};
    end
    nxt_wr_prev = wr_act;
    nxt_lanes = wr_act ? (lanes_ff | wr_lanes) : 2'b00;
    // data sampled while strobe high, committed when it falls
    nxt_wdat = wr_act ? ad_s : wdat_ff;
    nxt_mwr = wr_prev_ff && !wr_act;
    nxt_acc = rd_act ? ((acc_ff < 4'(ACC)) ? acc_ff + 4'h1 : acc_ff) : 4'h0;
    // low byte only for 8-bit modes; whole word for 16-bit ones
    nxt_oe = '0;
    if (rd_act) begin
      nxt_oe = (mode_ff == psm_pkg::PSM_W16 || mode_ff == psm_pkg::PSM_B16) ?
               {DW{1'b1}} : {{(DW-8){1'b0}}, 8'hFF};
    end
    // undefined (zero) until access time, then memory word
    nxt_rdat = (rd_act && acc_ff >= 4'(ACC - 1)) ? mem_rdata : '0;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff <= psm_pkg::PSM_IDLE;
      lat_ff <= '0;
      al_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b0;
      lanes_ff <= 2'b00;
      wdat_ff <= '0;
      acc_ff <= 4'h0;
      rdat_ff <= '0;
      oe_ff <= '0;
      mwr_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      lat_ff <= nxt_lat;
      al_prev_ff <= nxt_al_prev;
      wr_prev_ff <= nxt_wr_prev;
      lanes_ff <= nxt_lanes;
      wdat_ff <= nxt_wdat;
      acc_ff <= nxt_acc;
      rdat_ff <= nxt_rdat;
      oe_ff <= nxt_oe;
      mwr_ff <= nxt_mwr;
    end
  end
  logic [1:0] be_ff, nxt_be;
  always_comb begin
    nxt_be = (wr_prev_ff && !wr_act) ? lanes_ff : 2'b00;
  end
  always_ff @(posedge clk) begin
    if (rst) be_ff <= 2'b00;
    else be_ff <= nxt_be;
  end
  // 8-bit modes put the write byte on the low lane
  assign mem_addr = lat_mode ? lat_ff : a_s;
  assign mem_rd = rd_act;
  assign mem_wr = mwr_ff;
  assign mem_wr_be = be_ff;
  assign mem_wdata = wdat_ff;
  assign ad_out = rdat_ff;
  assign ad_oe = oe_ff;
  assign active_mode = mode_ff;
endmodule : psm_port

// *** core/psm_map.svh ***
// constants for the parallel slave port: clock period, widths, timing
// assumes a 20 MHz core clock
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH
`define PSM_CLK_NS 50
// read access time before data is valid, in ns
`define PSM_ACCESS_NS 150
`define PSM_ACCESS_CYC ((`PSM_ACCESS_NS + `PSM_CLK_NS - 1) / `PSM_CLK_NS)
`define PSM_ADDR_W 15
`define PSM_DATA_W 16
`endif

// *** core/psm_pkg.sv ***
// types for the parallel slave port
// assumes psm_map.svh for numeric constants
package psm_pkg;
  typedef enum logic [4:0] {
    PSM_IDLE = 5'h01,
    PSM_E8 = 5'h02,
    PSM_W16 = 5'h04,
    PSM_B16 = 5'h08,
    PSM_LAT8 = 5'h10
  } psm_mode_e;
endpackage : psm_pkg

// *** core/psm_sync.sv ***
// two-flop synchroniser, one per bit
// assumes inputs are asynchronous to clk
module psm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;
  always_comb begin
    nxt_meta = d;
    nxt_q = meta_ff;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end
  assign q = q_ff;
endmodule : psm_sync

// *** dv/psm_port_sva.sv ***
// checker for the slave port pins and write strobe
// assumes bind to psm_port, one clock domain
module psm_port_sva #(
  parameter int AW = 15,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select,
  input wire logic rd_strobe,
  input wire logic rw_select,
  input wire logic low_byte_write_strobe,
  input wire logic high_byte_write_strobe,
  input wire logic address_latch_strobe,
  input wire logic [DW-1:0] ad_oe,
  input wire logic [AW-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [1:0] mem_wr_be,
  input wire logic [4:0] active_mode
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic rq, ln, lq;
  assign rq = chip_select && rd_strobe;
  assign ln = low_byte_write_strobe || high_byte_write_strobe;
  assign lq = chip_select && rw_select && ln;
  // five cycles cover the three-flop strobe latency
  a_en_float: assert property ((active_mode == 5'h02 && !(rq && rw_select))[*5]
    |-> !ad_oe) else $error("enable mode drove idle bus");
  a_upper_off: assert property (active_mode inside {5'h02, 5'h10} |-> !ad_oe[15:8])
    else $error("8-bit mode drove upper lines");
  a_strobe_drive: assert property ((active_mode == 5'h04 && rq)[*5] |-> &ad_oe)
    else $error("strobe mode read not driving word");
  a_strobe_float: assert property ((active_mode == 5'h04 && !rq)[*5] |-> !ad_oe)
    else $error("strobe mode drove idle bus");
  a_lane_float: assert property ((active_mode == 5'h08 && !lq)[*5] |-> !ad_oe)
    else $error("lane mode drove idle bus");
  // memory read level follows the synchronised strobe, two flops behind
  a_rd_level: assert property ((active_mode inside {5'h04, 5'h10} && rq)[*4]
    |-> mem_rd) else $error("read strobe not forwarded to memory");
  a_rd_idle: assert property ((active_mode inside {5'h04, 5'h10} && !rq)[*4]
    |-> !mem_rd) else $error("memory read without a read strobe");
  a_wr_pulse: assert property (mem_wr |=> !mem_wr)
    else $error("write pulse longer than one cycle");
  // commit is seen three edges after the pin was first sampled low
  a_wr_after_fall: assert property (mem_wr && active_mode == 5'h04 |->
    mem_wr_be != 2'b00 && $past(ln, 4) && !$past(ln, 3))
    else $error("write commit without a fallen strobe");
  a_latch_hold: assert property ((active_mode == 5'h10 && !address_latch_strobe)[*6] |=> $stable(mem_addr))
    else $error("latched address moved");
  c_strobe_wr: cover property (active_mode == 5'h04 && mem_wr);
  c_lane_rd: cover property (active_mode == 5'h08 && &ad_oe);
  c_latch: cover property (active_mode == 5'h10 && $fell(address_latch_strobe));
endmodule : psm_port_sva

// *** dv/psm_host_model.sv ***
// host model: drives select, strobes, address and its side of the data bus
// assumes the bench passes the decoded mode index to acc
module psm_host_model (
  input wire logic clk,
  input wire logic [15:0] ad_out,
  input wire logic [15:0] ad_oe,
  output logic cs,
  output logic rd,
  output logic rw,
  output logic wl,
  output logic wh,
  output logic al,
  output logic [14:0] addr,
  output logic [15:0] ad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // bus access
  // ************************************************************
  logic [15:0] hd = 16'h0000;
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & hd);
  initial begin
    {cs, rd, rw, wl, wh, al} = 6'h00;
    addr = 15'h0000;
  end
  task automatic acc(input int m, input logic wr, input logic lt, input logic [1:0] ln,
    input logic [14:0] a, input logic [15:0] d, output logic [15:0] q,
    output logic [15:0] on, output logic [15:0] off);
    @(posedge clk);
    #5;
    cs = 1'b1;
    rw = !wr;
    addr = (m == 3) ? ~a : a;
    hd = (m == 3) ? {1'b0, a} : d;
    if (lt && m == 3) begin
      al = 1'b1;
      repeat (5) @(posedge clk);
      #5;
      al = 1'b0;
      repeat (5) @(posedge clk);
      #5;
    end
    if (m == 3) hd[7:0] = d[7:0];
    // released lines show the inverse of the last level
    if (!wr) hd = ~hd;
    if (m == 2 || (m == 1 && wr)) {wh, wl} = ln;
    else if (m == 3 && wr) wl = 1'b1;
    else rd = 1'b1;
    repeat (9) @(posedge clk);
    #5;
    q = ad_out;
    on = ad_oe;
    {rd, wl, wh} = 3'b000;
    repeat (5) @(posedge clk);
    #5;
    off = ad_oe;
  endtask : acc
endmodule : psm_host_model

// *** dv/parallel_slave_port_modes_tb_top.sv ***
// bench top: five strap setups, writes then reads in each mode
// assumes mem_rdata is a fixed map of mem_addr
module parallel_slave_port_modes_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************************************
  // harness and checks
  // ************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] st = 6'h13;
  logic cs, rd, rw, wl, wh, al, mem_wr, mem_rd;
  logic [14:0] addr, mem_addr;
  logic [15:0] ad_in, ad_out, ad_oe, mem_rdata, mem_wdata, mk;
  logic [1:0] mem_wr_be;
  logic [4:0] active_mode;
  logic [32:0] wq[$];
  logic [32:0] e;
  int n_fail = 0;
  int checks = 0;
  int seed = 24;
  always #25 clk = ~clk;
  assign mem_rdata = {~mem_addr[7:0], mem_addr[7:0] ^ 8'h5A};
  psm_port psm_port_i (.clk(clk), .rst(rst), .bus_mode_strap_0(st[0]), .bus_mode_strap_1(st[1]),
    .bus_mode_strap_2(st[2]), .bus_mode_strap_3(st[3]), .bus_mode_strap_4(st[4]),
    .small_package(st[5]), .chip_select(cs), .rd_strobe(rd), .rw_select(rw),
    .low_byte_write_strobe(wl), .high_byte_write_strobe(wh), .address_latch_strobe(al),
    .addr_in(addr), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_wr_be(mem_wr_be),
    .mem_wdata(mem_wdata), .active_mode(active_mode));
  psm_host_model psm_host_model_i (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe), .cs(cs),
    .rd(rd), .rw(rw), .wl(wl), .wh(wh), .al(al), .addr(addr), .ad_in(ad_in));
  task automatic chk(input string nm, input logic [32:0] x, input logic [32:0] g);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  always @(negedge clk) begin
    if (mem_wr === 1'b1) begin
      e = (wq.size() > 0) ? wq.pop_front() : '1;
      mk = {{8{e[17]}}, {8{e[16]}}};
      chk("wr", e, {mem_addr, mem_wr_be, mem_wdata & mk});
    end
  end
  initial begin
    #500000;
    n_fail++;
    finish_test();
  end
  initial begin
    logic [4:0] md[5] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h10};
    logic [5:0] sp[5] = '{6'h13, 6'h07, 6'h17, 6'h09, 6'h26};
    logic [14:0] a;
    logic [15:0] d, q, on, off, f;
    logic [1:0] be;
    int m;
    for (int k = 0; k < 5; k++) begin
      m = (k == 4) ? 3 : k;
      st = sp[k];
      rst = 1'b1;
      repeat (20) @(posedge clk);
      #5;
      rst = 1'b0;
      repeat (5) @(posedge clk);
      #5;
      chk("mode", 33'(md[k]), 33'(active_mode));
      for (int i = 0; i < 6; i++) begin
        if (!i[0]) a = 15'($random(seed)) & 15'h3FFF;
        if (!i[0]) d = 16'($random(seed));
        be = (m == 1 || m == 2) ? 2'(i / 2 + 1) : 2'b01;
        if (!i[0]) wq.push_back({a, be, d & {{8{be[1]}}, {8{be[0]}}}});
        psm_host_model_i.acc(m, !i[0], !(m == 3 && i[0]), 2'(i / 2 + 1), a, d, q, on, off);
        f = (m == 1 || m == 2) ? 16'hFFFF : 16'h00FF;
        if (i[0]) chk("oe", 33'(f), 33'(on));
        if (i[0]) chk("rd", 33'(f & {~a[7:0], a[7:0] ^ 8'h5A}), 33'(q & f));
        chk("off", 33'h0, 33'(off));
      end
    end
    chk("wq", 33'h0, 33'(wq.size()));
    finish_test();
  end
endmodule : parallel_slave_port_modes_tb_top
bind psm_port psm_port_sva #(.AW(AW), .DW(DW)) psm_port_sva_i (.clk(clk), .rst(rst),
  .chip_select(chip_select), .rd_strobe(rd_strobe), .rw_select(rw_select),
  .low_byte_write_strobe(low_byte_write_strobe), .high_byte_write_strobe(high_byte_write_strobe),
  .address_latch_strobe(address_latch_strobe), .ad_oe(ad_oe), .mem_addr(mem_addr),
  .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_wr_be(mem_wr_be), .active_mode(active_mode));
